// ===== crs_defines.vh
// Purpose: constants for the clock, reset and strap configuration block
// Assumes: apb byte addresses are four times the register index
// Notes: definitions only
`ifndef CRS_DEFINES_VH
`define CRS_DEFINES_VH
// register indices and address width
`define CRS_IDX_CLK0 8'h00
`define CRS_IDX_CLK1 8'h01
`define CRS_IDX_SER0 8'h02
`define CRS_IDX_SER1 8'h03
`define CRS_IDX_PDN 8'h04
`define CRS_IDX_STAT 8'h05
`define CRS_ADDR_W 12
// clock_control_0 fields
`define CRS_C0_REF_HI 7
`define CRS_C0_REF_LO 6
`define CRS_C0_SOFT_RST 4
`define CRS_C0_RATIO_HI 2
`define CRS_C0_RATIO_LO 1
`define CRS_C0_PUP 0
// clock_control_1 fields
`define CRS_C1_DIRECT 0
// serial_control_0 fields
`define CRS_S0_TDM_HI 5
`define CRS_S0_TDM_LO 4
`define CRS_S0_FMT_TDM 3
`define CRS_S0_RANGE_HI 2
`define CRS_S0_RANGE_LO 1
`define CRS_S0_MUTE 0
// serial_control_1 fields
`define CRS_S1_MASTER 0
`define CRS_S1_BIT_CLOCK_GENERATE 1
// powerdown_control fields
`define CRS_PD_TS 0
`define CRS_PD_PLL 1
`define CRS_PD_VREG 2
// reset values
`define CRS_RST_CLK0 8'h00
`define CRS_RST_CLK1 8'h00
`define CRS_RST_SER0 8'h01
`define CRS_RST_SER1 8'h00
`define CRS_RST_PDN 8'h00
// encodings
`define CRS_REF_MCLK 2'h0
`define CRS_REF_FRAME 2'h1
`define CRS_RANGE_48 2'h0
`define CRS_RANGE_96 2'h1
`define CRS_RANGE_LOWDLY 2'h3
`define CRS_RATIO_256 10'h100
`define CRS_RATIO_384 10'h180
`define CRS_RATIO_512 10'h200
`define CRS_RATIO_768 10'h300
`define CRS_CORE_BASE 10'h200
// timing
`define CRS_STAB_MS 300
`define CRS_CLK_KHZ 10000
`define CRS_STAB_CYC (`CRS_STAB_MS * `CRS_CLK_KHZ)
`endif

// ===== crs_strap_dec.v
// Purpose: decode standalone strap pins into serial and clock options
// Assumes: straps are static board ties
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
module crs_strap_dec (
   input wire i_standalone,
   input wire i_address0,
   input wire i_slave_strap,
   input wire i_ratio_strap,
   input wire i_tdm_a,
   input wire i_tdm_b,
   output wire o_serial_master,
   output wire [1:0] o_ratio_code,
   output wire o_format_tdm,
   output wire [1:0] o_tdm_lines,
   output wire o_frame_50
);
   // strap low selects master, high selects slave
   assign o_serial_master = ~i_slave_strap;
   assign o_ratio_code = {1'b0, i_ratio_strap};
   // tdm only when both standalone and address0 straps are high
   assign o_format_tdm = i_standalone & i_address0;
   // 00 tdm4, 01 tdm8, 10 tdm16 pulse; 11 tdm8 with 50% frame
   assign o_tdm_lines = (i_tdm_a & i_tdm_b) ? 2'h1 : {i_tdm_a, i_tdm_b};
   assign o_frame_50 = i_tdm_a & i_tdm_b;
endmodule

// ===== crs_clock_config.v
// Purpose: clock source, power-up/reset and strap configuration of a multichannel dac
// Assumes: all pins synchronous to i_clk; registers reached over apb
// Notes: one wait state on every apb access
// Functional notes
// - pll runs after reset without any register write
// - reference select 01 locks pll to frame clock, no master clock needed
// - bit clock generate 1 with slave port makes bit clock internally
// - ratio code selects 256/384/512/768 fs, halved at 96k, quartered at 192k
// - power-up reset pin low disables everything until driven high
// - master power-up cleared idles device, registers keep values
// - sensor, pll and regulator power-down bits act alone
// - soft reset restores register defaults, clocks default, outputs stay on; defaults clear power-up and set mute, so core idles and mutes
// - standalone strap high runs without control port, defaults plus straps
// - straps choose master/slave, 256/384 fs with pll, i2s/tdm
// - tdm in standalone only with standalone and address0 straps high
// - tdm straps: 00 tdm4, 01 tdm8, 10 tdm16 pulse, 11 tdm8 50%
// - standalone master clock output buffers master clock input
// - range field: 00 48k, 01 96k, 1x 192k, 11 adds low delay
// - core clock is 512, 256, 128 fs per range
`timescale 1ns/1ps
`include "crs_defines.vh"
module crs_clock_config #(
   parameter STAB_CYCLES = `CRS_STAB_CYC,
   parameter CNT_W = 22
) (
   input wire i_clk,
   input wire i_reset,
   input wire i_power_up_reset_n,
   input wire i_master_clock_in,
   input wire i_frame_clock,
   input wire i_standalone_strap,
   input wire i_address0_strap,
   input wire i_slave_strap,
   input wire i_ratio_strap,
   input wire i_tdm_strap_a,
   input wire i_tdm_strap_b,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [`CRS_ADDR_W-1:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg o_pready,
   output reg [31:0] o_prdata,
   output reg o_pslverr,
   output reg o_master_clock_out,
   output reg o_pll_enable,
   output reg o_pll_ref_frame,
   output reg o_direct_mclk,
   output reg [9:0] o_mclk_ratio,
   output reg [9:0] o_core_ratio,
   output reg o_low_delay,
   output reg o_bit_clock_internal,
   output reg o_serial_master,
   output reg o_format_tdm,
   output reg [1:0] o_tdm_lines,
   output reg o_frame_50,
   output reg o_idle,
   output reg o_temp_sensor_on,
   output reg o_regulator_on,
   output reg o_mute_all,
   output reg o_stable,
   output reg o_standalone
);
   // control register file, one byte per register
   reg [7:0] clk0_r;
   reg [7:0] clk1_r;
   reg [7:0] ser0_r;
   reg [7:0] ser1_r;
   reg [7:0] pdn_r;

   // run state and strap snapshot, taken once at pin release
   reg run_r;
   reg sa_r;
   reg sa_master_r;
   reg [1:0] sa_ratio_r;
   reg sa_tdm_r;
   reg [1:0] sa_lines_r;
   reg sa_f50_r;

   // stabilisation counter; CNT_W must cover STAB_CYCLES
   reg [CNT_W-1:0] stab_cnt_r;
   reg stab_r;

   // strap decoder outputs, only looked at on the release edge
   wire dec_master;
   wire [1:0] dec_ratio;
   wire dec_tdm;
   wire [1:0] dec_lines;
   wire dec_f50;

   // apb decode
   wire [`CRS_ADDR_W-3:0] idx;
   wire acc;
   wire wr_do;
   wire soft_rst;

   // read mux and effective settings, all combinational
   reg [31:0] rd_data;
   reg rd_err;
   reg [1:0] eff_ref;
   reg [1:0] eff_ratio;
   reg [1:0] eff_range;
   reg [1:0] shift;
   reg [9:0] base_ratio;
   reg eff_pup;
   reg eff_master;

   crs_strap_dec crs_strap_dec_i (
      .i_standalone(i_standalone_strap),
      .i_address0(i_address0_strap),
      .i_slave_strap(i_slave_strap),
      .i_ratio_strap(i_ratio_strap),
      .i_tdm_a(i_tdm_strap_a),
      .i_tdm_b(i_tdm_strap_b),
      .o_serial_master(dec_master),
      .o_ratio_code(dec_ratio),
      .o_format_tdm(dec_tdm),
      .o_tdm_lines(dec_lines),
      .o_frame_50(dec_f50)
   );

   // apb decode; write lands at the edge that samples pready high
   assign idx = i_paddr[`CRS_ADDR_W-1:2];
   assign acc = i_psel & i_penable;
   // a write is dropped in standalone mode or before the pin has been seen high
   assign wr_do = acc & o_pready & i_pwrite & ~rd_err & run_r & ~sa_r;
   // soft reset acts as a strobe and is never stored
   assign soft_rst = wr_do && (idx == `CRS_IDX_CLK0) && i_pwdata[`CRS_C0_SOFT_RST];

   // run state follows the power-up reset pin; straps caught at release
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         run_r <= 1'b0;
         sa_r <= 1'b0;
         sa_master_r <= 1'b0;
         sa_ratio_r <= 2'h0;
         sa_tdm_r <= 1'b0;
         sa_lines_r <= 2'h0;
         sa_f50_r <= 1'b0;
      end else begin
         // pin delayed one edge; outputs follow one edge later
         run_r <= i_power_up_reset_n;
         if (i_power_up_reset_n && !run_r) begin
            // straps are sampled once so a loose tie cannot flip modes later
            sa_r <= i_standalone_strap;
            sa_master_r <= dec_master;
            sa_ratio_r <= dec_ratio;
            sa_tdm_r <= dec_tdm;
            sa_lines_r <= dec_lines;
            sa_f50_r <= dec_f50;
         end
      end
   end

   // stabilisation wait after release, restarted whenever the pin drops
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         stab_cnt_r <= {CNT_W{1'b0}};
         stab_r <= 1'b0;
      end else if (!run_r) begin
         stab_cnt_r <= {CNT_W{1'b0}};
         stab_r <= 1'b0;
      end else if (!stab_r) begin
         // counter freezes once the flag is up, so it never wraps
         if (stab_cnt_r == STAB_CYCLES[CNT_W-1:0] - 1'b1) begin
            stab_r <= 1'b1;
         end
         stab_cnt_r <= stab_cnt_r + 1'b1;
      end
   end

   // control registers; reset pin low or soft reset restores defaults
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         clk0_r <= `CRS_RST_CLK0;
         clk1_r <= `CRS_RST_CLK1;
         ser0_r <= `CRS_RST_SER0;
         ser1_r <= `CRS_RST_SER1;
         pdn_r <= `CRS_RST_PDN;
      end else if (!i_power_up_reset_n || soft_rst) begin
         // soft reset leaves the stabilisation count alone
         clk0_r <= `CRS_RST_CLK0;
         clk1_r <= `CRS_RST_CLK1;
         ser0_r <= `CRS_RST_SER0;
         ser1_r <= `CRS_RST_SER1;
         pdn_r <= `CRS_RST_PDN;
      end else if (wr_do) begin
         // status index falls through: it is read only
         if (idx == `CRS_IDX_CLK0) begin
            // soft reset bit is not kept, so it reads back as 0
            clk0_r <= i_pwdata[7:0] & 8'hef;
         end else if (idx == `CRS_IDX_CLK1) begin
            clk1_r <= i_pwdata[7:0];
         end else if (idx == `CRS_IDX_SER0) begin
            ser0_r <= i_pwdata[7:0];
         end else if (idx == `CRS_IDX_SER1) begin
            ser1_r <= i_pwdata[7:0];
         end else if (idx == `CRS_IDX_PDN) begin
            pdn_r <= i_pwdata[7:0];
         end
      end
   end

   // read mux and unmapped-address detection
   always @* begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      if (idx == `CRS_IDX_CLK0) begin
         rd_data = {24'h00_0000, clk0_r};
      end else if (idx == `CRS_IDX_CLK1) begin
         rd_data = {24'h00_0000, clk1_r};
      end else if (idx == `CRS_IDX_SER0) begin
         rd_data = {24'h00_0000, ser0_r};
      end else if (idx == `CRS_IDX_SER1) begin
         rd_data = {24'h00_0000, ser1_r};
      end else if (idx == `CRS_IDX_PDN) begin
         rd_data = {24'h00_0000, pdn_r};
      end else if (idx == `CRS_IDX_STAT) begin
         // status shows the live mute, idle and pll output levels and the internal sa_r and stab_r flags
         rd_data = {24'h00_0000, 3'h0, o_mute_all, o_idle, o_pll_enable, sa_r, stab_r};
      end else begin
         rd_err = 1'b1;
      end
   end

   // apb answer: pready rises one cycle into the access phase
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_pready <= 1'b0;
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else if (acc && !o_pready) begin
         // one answer per access phase; the next cycle drops it again
         o_pready <= 1'b1;
         o_prdata <= i_pwrite ? 32'h0000_0000 : rd_data;
         o_pslverr <= rd_err;
      end else begin
         o_pready <= 1'b0;
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end
   end

   // effective settings: straps override registers in standalone mode
   always @* begin
      eff_ref = sa_r ? `CRS_REF_MCLK : clk0_r[`CRS_C0_REF_HI:`CRS_C0_REF_LO];
      eff_ratio = sa_r ? sa_ratio_r : clk0_r[`CRS_C0_RATIO_HI:`CRS_C0_RATIO_LO];
      eff_range = sa_r ? `CRS_RANGE_48 : ser0_r[`CRS_S0_RANGE_HI:`CRS_S0_RANGE_LO];
      eff_pup = sa_r | clk0_r[`CRS_C0_PUP];
      eff_master = sa_r ? sa_master_r : ser1_r[`CRS_S1_MASTER];
      // 48k range no shift, 96k halves, both 192k codes quarter
      if (eff_range == `CRS_RANGE_48) begin
         shift = 2'h0;
      end else if (eff_range == `CRS_RANGE_96) begin
         shift = 2'h1;
      end else begin
         shift = 2'h2;
      end
      // ratio at the 48k range, before the range shift
      case (eff_ratio)
         2'h0: base_ratio = `CRS_RATIO_256;
         2'h1: base_ratio = `CRS_RATIO_384;
         2'h2: base_ratio = `CRS_RATIO_512;
         default: base_ratio = `CRS_RATIO_768;
      endcase
   end

   // registered clock and power outputs; everything off while pin is low
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_master_clock_out <= 1'b0;
         o_pll_enable <= 1'b0;
         o_pll_ref_frame <= 1'b0;
         o_direct_mclk <= 1'b0;
         o_mclk_ratio <= 10'h000;
         o_core_ratio <= 10'h000;
         o_low_delay <= 1'b0;
         o_bit_clock_internal <= 1'b0;
         o_serial_master <= 1'b0;
         o_format_tdm <= 1'b0;
         o_tdm_lines <= 2'h0;
         o_frame_50 <= 1'b0;
         o_idle <= 1'b1;
         o_temp_sensor_on <= 1'b0;
         o_regulator_on <= 1'b0;
         o_mute_all <= 1'b1;
         o_stable <= 1'b0;
         o_standalone <= 1'b0;
      end else if (!run_r) begin
         // same levels as under i_reset, so the board sees one off state
         o_master_clock_out <= 1'b0;
         o_pll_enable <= 1'b0;
         o_pll_ref_frame <= 1'b0;
         o_direct_mclk <= 1'b0;
         o_mclk_ratio <= 10'h000;
         o_core_ratio <= 10'h000;
         o_low_delay <= 1'b0;
         o_bit_clock_internal <= 1'b0;
         o_serial_master <= 1'b0;
         o_format_tdm <= 1'b0;
         o_tdm_lines <= 2'h0;
         o_frame_50 <= 1'b0;
         o_idle <= 1'b1;
         o_temp_sensor_on <= 1'b0;
         o_regulator_on <= 1'b0;
         o_mute_all <= 1'b1;
         o_stable <= 1'b0;
         o_standalone <= 1'b0;
      end else begin
         // buffered copy of the master clock input, one cycle late
         o_master_clock_out <= i_master_clock_in;
         // section power-downs ignore the master power-up bit
         o_pll_enable <= ~pdn_r[`CRS_PD_PLL];
         o_temp_sensor_on <= ~pdn_r[`CRS_PD_TS];
         o_regulator_on <= ~pdn_r[`CRS_PD_VREG];
         // reference select: frame clock or master clock input
         o_pll_ref_frame <= (eff_ref == `CRS_REF_FRAME);
         // direct path needs the host to have stopped the pll first
         o_direct_mclk <= ~sa_r & clk1_r[`CRS_C1_DIRECT] & pdn_r[`CRS_PD_PLL];
         // ratios are given in units of fs
         o_mclk_ratio <= base_ratio >> shift;
         o_core_ratio <= `CRS_CORE_BASE >> shift;
         o_low_delay <= (eff_range == `CRS_RANGE_LOWDLY);
         // serial port options; the straps win in standalone mode
         o_bit_clock_internal <= ~sa_r & ser1_r[`CRS_S1_BIT_CLOCK_GENERATE] & ~eff_master;
         o_serial_master <= eff_master;
         o_format_tdm <= sa_r ? sa_tdm_r : ser0_r[`CRS_S0_FMT_TDM];
         o_tdm_lines <= sa_r ? sa_lines_r : ser0_r[`CRS_S0_TDM_HI:`CRS_S0_TDM_LO];
         o_frame_50 <= sa_r & sa_tdm_r & sa_f50_r;
         // master power-up idles and mutes the core, registers are kept
         o_idle <= ~eff_pup;
         // muted until settled and, with a control port, until host unmutes
         o_mute_all <= ~stab_r | ~eff_pup | (~sa_r & ser0_r[`CRS_S0_MUTE]);
         o_stable <= stab_r;
         o_standalone <= sa_r;
      end
   end
endmodule

// ===== crs_clock_config_monitor.sv
// Purpose: assertions on the clock, reset and strap outputs
// Assumes: STAB_CYCLES equals the instance value
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module crs_clock_config_monitor #(
   parameter STAB_CYCLES = 20
) (
   input wire i_clk,
   input wire i_reset,
   input wire i_power_up_reset_n,
   input wire i_master_clock_in,
   input wire o_master_clock_out,
   input wire o_pll_enable,
   input wire o_direct_mclk,
   input wire [9:0] o_mclk_ratio,
   input wire [9:0] o_core_ratio,
   input wire o_low_delay,
   input wire o_bit_clock_internal,
   input wire o_serial_master,
   input wire o_format_tdm,
   input wire [1:0] o_tdm_lines,
   input wire o_frame_50,
   input wire o_idle,
   input wire o_mute_all,
   input wire o_stable,
   input wire o_standalone
);
   int up_cnt;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);
   // cycles the pin has been high; saturates so a long run cannot wrap it
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset || !i_power_up_reset_n)
         up_cnt <= 0;
      else if (up_cnt < STAB_CYCLES + 8)
         up_cnt <= up_cnt + 1;
   end
   chk_stable_wait: assert property ($rose(o_stable) |-> up_cnt inside {[STAB_CYCLES + 1:STAB_CYCLES + 3]})
      else $error("stable flag rose off time");
   chk_stable_late: assert property (up_cnt == STAB_CYCLES + 8 |-> o_stable)
      else $error("stable flag missing");
   chk_pin_low_off: assert property (!$past(i_power_up_reset_n, 2) && !$past(i_power_up_reset_n)
      |-> o_idle && o_mute_all && !o_pll_enable && !o_stable && !o_standalone)
      else $error("active while pin low");
   chk_pll_start: assert property ($past(i_power_up_reset_n, 3) && !$past(i_power_up_reset_n, 4) |-> o_pll_enable)
      else $error("pll off after release");
   chk_mute_hold: assert property (!o_stable && !$past(o_stable) |-> o_mute_all)
      else $error("unmuted before stable");
   chk_direct_pd: assert property (o_direct_mclk |-> !o_pll_enable && !o_standalone)
      else $error("direct clock with pll on");
   chk_low_delay: assert property (o_low_delay |-> o_core_ratio == 10'h080 && o_mclk_ratio <= 10'h0c0)
      else $error("low delay ratios wrong");
   chk_bclk_slave: assert property (o_bit_clock_internal |-> !o_serial_master && !o_standalone)
      else $error("internal bit clock as master");
   chk_wide_frame: assert property (o_frame_50 |-> o_format_tdm && o_tdm_lines == 2'h1)
      else $error("wide frame outside tdm8");
   chk_mclk_copy: assert property (o_standalone && $past(o_standalone)
      |-> o_master_clock_out == $past(i_master_clock_in))
      else $error("master clock out not a copy");
endmodule
bind crs_clock_config crs_clock_config_monitor #(.STAB_CYCLES(STAB_CYCLES)) crs_clock_config_monitor_i (
   .i_clk(i_clk),
   .i_reset(i_reset),
   .i_power_up_reset_n(i_power_up_reset_n),
   .i_master_clock_in(i_master_clock_in),
   .o_master_clock_out(o_master_clock_out),
   .o_pll_enable(o_pll_enable),
   .o_direct_mclk(o_direct_mclk),
   .o_mclk_ratio(o_mclk_ratio),
   .o_core_ratio(o_core_ratio),
   .o_low_delay(o_low_delay),
   .o_bit_clock_internal(o_bit_clock_internal),
   .o_serial_master(o_serial_master),
   .o_format_tdm(o_format_tdm),
   .o_tdm_lines(o_tdm_lines),
   .o_frame_50(o_frame_50),
   .o_idle(o_idle),
   .o_mute_all(o_mute_all),
   .o_stable(o_stable),
   .o_standalone(o_standalone)
);

// ===== crs_host_model.sv
// Purpose: host and board side: power-up pin, straps, pin clocks
// Assumes: bench asks for pin level and strap set
// Notes: straps only change while the pin is low
`timescale 1ns/1ps
module crs_host_model (
   input wire i_clk,
   input wire i_run,
   input wire [5:0] i_straps,
   output logic o_power_up_reset_n,
   output logic o_master_clock_in,
   output logic o_frame_clock,
   output logic [5:0] o_strap_pins
);
   // pins settle at the first edge, well inside the bench's reset
   logic [7:0] div_r = 8'h00;
   // pin rises only once supplies count as stable
   always @(posedge i_clk) begin
      o_power_up_reset_n <= i_run;
      o_strap_pins <= i_straps;
      div_r <= div_r + 8'h01;
   end
   // master clock flips each cycle so a stale copy shows
   assign o_master_clock_in = div_r[0];
   assign o_frame_clock = div_r[7];
endmodule

// ===== test_clock_reset_standalone_config.sv
// Purpose: self-checking bench for the clock, reset and strap block
// Assumes: stabilisation shortened to STAB cycles
// Notes: apb answers judged against a queue of notes
`timescale 1ns/1ps
`include "crs_defines.vh"
module test_clock_reset_standalone_config;
   localparam int STAB = 20;
   logic i_clk = 1'b0, i_reset = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, run = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0, o_prdata, r, seed = 32'h0000004c;
   logic i_power_up_reset_n, i_master_clock_in, i_frame_clock, i_standalone_strap, i_address0_strap;
   logic i_slave_strap, i_ratio_strap, i_tdm_strap_a, i_tdm_strap_b, o_pready, o_pslverr, o_master_clock_out;
   logic o_pll_enable, o_pll_ref_frame, o_direct_mclk, o_low_delay, o_bit_clock_internal, o_serial_master;
   logic o_format_tdm, o_frame_50, o_idle, o_temp_sensor_on, o_regulator_on, o_mute_all, o_stable, o_standalone;
   logic [9:0] o_mclk_ratio, o_core_ratio;
   logic [9:0] rat[4] = '{`CRS_RATIO_256, `CRS_RATIO_384, `CRS_RATIO_512, `CRS_RATIO_768};
   logic [1:0] o_tdm_lines;
   logic [1:0] tdl[4] = '{2'h0, 2'h1, 2'h2, 2'h1};
   logic [5:0] straps = 6'h00;
   logic [32:0] exp_q[$];
   int err_total = 0, total_checks = 0;
   always #50 i_clk = ~i_clk;
   crs_clock_config #(.STAB_CYCLES(STAB), .CNT_W(22)) crs_clock_config_i (.*);
   crs_host_model crs_host_model_i (.i_clk(i_clk), .i_run(run), .i_straps(straps),
      .o_power_up_reset_n(i_power_up_reset_n), .o_master_clock_in(i_master_clock_in), .o_frame_clock(i_frame_clock),
      .o_strap_pins({i_standalone_strap, i_address0_strap, i_slave_strap, i_ratio_strap, i_tdm_strap_a, i_tdm_strap_b}));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic ck(input string nm, input logic [32:0] e, input logic [32:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // one transfer held until pready; the note is queued first
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [32:0] e);
      int n;
      n = 0;
      exp_q.push_back(e);
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= {24'h0, d};
      @(posedge i_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 20);
      if (o_pready !== 1'b1) begin
         err_total++;
         final_report();
      end
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] d);
      apb(1'b0, a, 8'h00, {25'h0, d});
   endtask
   task automatic st();
      repeat (3) @(posedge i_clk);
   endtask
   // pin low, new straps, pin high, bounded wait for stable
   task automatic power(input logic [5:0] s);
      int n;
      n = 0;
      run <= 1'b0;
      repeat (4) @(posedge i_clk);
      straps <= s;
      @(posedge i_clk);
      run <= 1'b1;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_stable !== 1'b1 && n < 100);
      if (o_stable !== 1'b1) begin
         err_total++;
         final_report();
      end
   endtask
   // oldest note against each answer
   always @(posedge i_clk) begin
      if (o_pready === 1'b1) ck("apb", exp_q.size() > 0 ? exp_q.pop_front() : 33'h1ffffffff, {o_pslverr, o_prdata});
   end
   initial begin
      repeat (6) @(posedge i_clk);
      i_reset <= 1'b0;
      power(6'h00);
      ck("pll", 1, o_pll_enable);
      ck("mute", 1, o_mute_all);
      rd(12'h000, `CRS_RST_CLK0);
      rd(12'h008, `CRS_RST_SER0);
      apb(1'b1, 12'h018, 8'hff, {1'b1, 32'h0});
      wr(12'h000, 8'h01);
      st();
      ck("up", 0, o_idle);
      wr(12'h008, 8'h00);
      st();
      ck("unmute", 0, o_mute_all);
      for (int i = 0; i < 16; i++) begin
         r = rnd();
         wr(12'h000, {1'b0, r[6], 3'h0, i[1:0], 1'b1});
         wr(12'h008, {5'h00, i[3:2], 1'b0});
         st();
         ck("ratio", rat[i[1:0]] >> (i[3] ? 2 : i[2]), o_mclk_ratio);
         ck("core", `CRS_CORE_BASE >> (i[3] ? 2 : i[2]), o_core_ratio);
         ck("lowdly", i[3:2] == 2'h3, o_low_delay);
         ck("ref", r[6], o_pll_ref_frame);
      end
      wr(12'h00c, 8'h02);
      st();
      ck("bclk", 1, o_bit_clock_internal);
      for (int k = 0; k < 3; k++) begin
         wr(12'h010, 8'h01 << k);
         st();
         ck("sensor", k != 0, o_temp_sensor_on);
         ck("pllpd", k != 1, o_pll_enable);
         ck("vreg", k != 2, o_regulator_on);
      end
      wr(12'h010, 8'h02);
      wr(12'h004, 8'h01);
      st();
      ck("direct", 1, o_direct_mclk);
      wr(12'h000, 8'h00);
      st();
      ck("idle", 1, o_idle);
      rd(12'h004, 8'h01);
      wr(12'h000, 8'h10);
      rd(12'h004, `CRS_RST_CLK1);
      rd(12'h00c, `CRS_RST_SER1);
      rd(12'h010, `CRS_RST_PDN);
      ck("stable", 1, o_stable);
      run <= 1'b0;
      repeat (4) @(posedge i_clk);
      ck("off", 0, o_pll_enable);
      wr(12'h008, 8'h00);
      rd(12'h008, `CRS_RST_SER0);
      for (int t = 0; t < 4; t++) begin
         power({2'h3, t[0], t[1], t[1:0]});
         st();
         ck("sa", 1, o_standalone);
         ck("sam", !t[0], o_serial_master);
         ck("sar", rat[t[1]], o_mclk_ratio);
         ck("tdm", 1, o_format_tdm);
         ck("lines", tdl[t], o_tdm_lines);
         ck("f50", t == 3, o_frame_50);
         ck("samute", 0, o_mute_all);
         wr(12'h000, 8'h00);
         st();
         ck("saup", 0, o_idle);
      end
      power(6'h23);
      ck("notdm", 0, o_format_tdm);
      final_report();
   end
endmodule
